// *** host_model.sv ***
// host_model: host controller that drives the direction and brake pins
`timescale 1ns/1ps
module host_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// bench commands
	input wire logic i_flip,
	input wire logic i_brake,
	// pins toward the device
	output logic o_direction,
	output logic o_brake_request
);
	// pins move only just after an edge and then hold until the next command;
	// reset gives the toggle a defined start, the device flushes any early unknown
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_direction <= 1'b0;
			o_brake_request <= 1'b0;
		end else begin
			if (i_flip) begin
				o_direction <= ~o_direction;
			end
			o_brake_request <= i_brake;
		end
	end
endmodule // host_model

// *** motor_protection_supervisor.sv ***
// motor_protection_supervisor: decides the bridge drive state from protection inputs
//
// Contract
// [RULE_01] overcurrent holds pwm off, then auto resumes
// [RULE_02] no rotation pulse for interval enters stall
// [RULE_03] stall drives free-run: one high on
// [RULE_04] same interval times free-run to standby
// [RULE_05] grounded timer pin disables stall and standby
// [RULE_06] overtemperature turns all outputs off until cleared
// [RULE_07] undervoltage forces short brake until released
// [RULE_08] interval is 256 oscillator periods counted
// [RULE_09] all-off outranks free-run and short brake
`timescale 1ns/1ps
module motor_protection_supervisor
	import prot_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// analog comparator flags and pins, all asynchronous
	input wire logic i_current_sense_over,
	input wire logic i_hall_pulse,
	input wire logic i_lock_timer_cap_input,
	input wire logic i_lock_timer_grounded,
	input wire logic i_over_temp,
	input wire logic i_undervoltage,
	// host control pins
	input wire logic i_direction,
	input wire logic i_brake_request,
	// bridge drive
	output bridge_t o_bridge,
	output drive_t o_drive_state,
	output logic o_standby_state
);
	localparam int NPIN = 8;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s;
	logic oc_s, hall_s, osc_s, gnd_s, ot_s, uv_s, dir_s, brk_s;

	assign pin_raw = {i_current_sense_over, i_hall_pulse, i_lock_timer_cap_input,
		i_lock_timer_grounded, i_over_temp, i_undervoltage, i_direction, i_brake_request};

	// every pin passes two flip-flops before use
	sync2 #(.W(NPIN)) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(pin_raw),
		.o_q(pin_s)
	);
	assign {oc_s, hall_s, osc_s, gnd_s, ot_s, uv_s, dir_s, brk_s} = pin_s;

	// edge history of synchronised pins
	logic hall_d_ff, osc_d_ff, dir_d_ff;
	logic hall_edge, osc_edge, dir_edge;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hall_d_ff <= 1'b0;
			osc_d_ff <= 1'b0;
			dir_d_ff <= 1'b0;
		end else begin
			hall_d_ff <= hall_s;
			osc_d_ff <= osc_s;
			dir_d_ff <= dir_s;
		end
	end
	assign hall_edge = hall_s & ~hall_d_ff;
	assign osc_edge = osc_s & ~osc_d_ff;
	assign dir_edge = dir_s ^ dir_d_ff;

	// overcurrent blanking timer; a new trip while counting restarts nothing
	logic [OC_CNT_W-1:0] oc_cnt_ff, nxt_oc_cnt;
	logic oc_hold;
	always_comb begin
		nxt_oc_cnt = oc_cnt_ff;
		if (oc_cnt_ff != OC_CNT_RST) begin
			nxt_oc_cnt = oc_cnt_ff - 9'h001; // see [RULE_01]
		end else if (oc_s) begin
			nxt_oc_cnt = OC_LOAD; // see [RULE_01]
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			oc_cnt_ff <= OC_CNT_RST;
		end else begin
			oc_cnt_ff <= nxt_oc_cnt;
		end
	end
	assign oc_hold = (oc_cnt_ff != OC_CNT_RST);

	// stall supervisor: lock interval counts oscillator edges, hall edges restart it
	stall_t stall_ff, nxt_stall;
	logic [LOCK_CNT_W-1:0] lock_cnt_ff, nxt_lock_cnt;
	logic release_stall;
	logic lock_done;
	assign release_stall = dir_edge | brk_s | uv_s | gnd_s;
	assign lock_done = (lock_cnt_ff == LOCK_TERM); // see [RULE_08]
	always_comb begin
		nxt_stall = stall_ff;
		nxt_lock_cnt = lock_cnt_ff;
		if (release_stall) begin
			// grounded timer pin keeps supervisor idle; no stall, no standby
			nxt_stall = ST_RUN; // see [RULE_05]
			nxt_lock_cnt = LOCK_CNT_RST;
		end else begin
			unique case (stall_ff)
				ST_RUN: begin
					if (hall_edge) begin
						nxt_lock_cnt = LOCK_CNT_RST;
					end else if (lock_done) begin
						nxt_stall = ST_FREE; // see [RULE_02]
						nxt_lock_cnt = LOCK_CNT_RST;
					end else if (osc_edge) begin
						nxt_lock_cnt = lock_cnt_ff + 9'h001; // see [RULE_08]
					end
				end
				ST_FREE: begin
					// motor at rest means no hall edges for a full interval
					if (hall_edge) begin
						nxt_lock_cnt = LOCK_CNT_RST;
					end else if (lock_done) begin
						nxt_stall = ST_STANDBY; // see [RULE_04]
					end else if (osc_edge) begin
						nxt_lock_cnt = lock_cnt_ff + 9'h001;
					end
				end
				ST_STANDBY: begin
					nxt_lock_cnt = LOCK_CNT_RST;
				end
				default: begin
					nxt_stall = ST_RUN;
					nxt_lock_cnt = LOCK_CNT_RST;
				end
			endcase
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			stall_ff <= ST_RUN;
			lock_cnt_ff <= LOCK_CNT_RST;
		end else begin
			stall_ff <= nxt_stall;
			lock_cnt_ff <= nxt_lock_cnt;
		end
	end

	// output priority: all-off, then short brake, then free-run, then pwm hold
	drive_t drive_ff, nxt_drive;
	bridge_t bridge_ff, nxt_bridge;
	logic stby_ff, nxt_stby;
	logic [1:0] settle_ff, nxt_settle;
	always_comb begin
		nxt_bridge = '{high_on: 3'h0, low_on: 3'h0, pwm_en: 1'b1};
		nxt_drive = DRV_NORMAL;
		if (ot_s) begin
			nxt_drive = DRV_ALL_OFF; // see [RULE_06] [RULE_09]
			nxt_bridge = '{high_on: 3'h0, low_on: 3'h0, pwm_en: 1'b0};
		end else if (uv_s) begin
			nxt_drive = DRV_SHORT_BRAKE; // see [RULE_07]
			nxt_bridge = '{high_on: 3'h0, low_on: 3'h7, pwm_en: 1'b0};
		end else if (stall_ff != ST_RUN) begin
			nxt_drive = DRV_FREE_RUN; // see [RULE_03]
			nxt_bridge = '{high_on: 3'h1, low_on: 3'h0, pwm_en: 1'b0};
		end else if (oc_hold) begin
			nxt_drive = DRV_PWM_HOLD; // see [RULE_01]
			nxt_bridge.pwm_en = 1'b0;
		end
		nxt_stby = (stall_ff == ST_STANDBY); // see [RULE_04]
		// synchronisers read fault-free just after reset; keep the safe brake
		// until they hold real pin levels, else a lockout could see drive for two cycles
		nxt_settle = {settle_ff[0], 1'b1};
		if (!settle_ff[1]) begin
			nxt_drive = DRV_SHORT_BRAKE; // see [RULE_07]
			nxt_bridge = BRIDGE_RST;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			drive_ff <= DRV_SHORT_BRAKE;
			bridge_ff <= BRIDGE_RST;
			stby_ff <= 1'b0;
			settle_ff <= 2'h0;
		end else begin
			drive_ff <= nxt_drive;
			bridge_ff <= nxt_bridge;
			stby_ff <= nxt_stby;
			settle_ff <= nxt_settle;
		end
	end
	assign o_bridge = bridge_ff;
	assign o_drive_state = drive_ff;
	assign o_standby_state = stby_ff;

	// checks
	property p_oc_hold;
		@(posedge i_clk) disable iff (i_rst)
		(oc_s && !oc_hold) |=> oc_hold [*8];
	endproperty
	a_oc_hold: assert property (p_oc_hold) else $error("pwm hold too short"); // see [RULE_01]

	property p_stall_enter;
		@(posedge i_clk) disable iff (i_rst)
		(stall_ff == ST_RUN && lock_done && !release_stall && !hall_edge) |=> stall_ff == ST_FREE;
	endproperty
	a_stall_enter: assert property (p_stall_enter) else $error("stall not entered"); // see [RULE_02]

	property p_free_run;
		@(posedge i_clk) disable iff (i_rst)
		(stall_ff != ST_RUN && !ot_s && !uv_s) |=> o_bridge.high_on == 3'h1 && o_bridge.low_on == 3'h0;
	endproperty
	a_free_run: assert property (p_free_run) else $error("free-run pattern wrong"); // see [RULE_03]

	property p_standby;
		@(posedge i_clk) disable iff (i_rst)
		(stall_ff == ST_STANDBY) |=> o_standby_state;
	endproperty
	a_standby: assert property (p_standby) else $error("standby flag missing"); // see [RULE_04]

	property p_gnd_off;
		@(posedge i_clk) disable iff (i_rst)
		gnd_s |=> stall_ff == ST_RUN ##1 !o_standby_state;
	endproperty
	a_gnd_off: assert property (p_gnd_off) else $error("stall active with timer grounded"); // see [RULE_05]

	property p_all_off;
		@(posedge i_clk) disable iff (i_rst)
		ot_s |=> o_bridge.high_on == 3'h0 && o_bridge.low_on == 3'h0 && o_drive_state == DRV_ALL_OFF;
	endproperty
	a_all_off: assert property (p_all_off) else $error("outputs on during overtemperature"); // see [RULE_06] [RULE_09]

	property p_short_brake;
		@(posedge i_clk) disable iff (i_rst)
		(uv_s && !ot_s) |=> o_bridge.low_on == 3'h7 && o_bridge.high_on == 3'h0;
	endproperty
	a_short_brake: assert property (p_short_brake) else $error("undervoltage not braking"); // see [RULE_07]

	property p_lock_bound;
		@(posedge i_clk) disable iff (i_rst)
		lock_cnt_ff <= LOCK_TERM;
	endproperty
	a_lock_bound: assert property (p_lock_bound) else $error("lock counter past 256"); // see [RULE_08]
endmodule // motor_protection_supervisor

// *** motor_protection_supervisor_tb.sv ***
// motor_protection_supervisor_tb: directed bench for the protection supervisor
`timescale 1ns/1ps
module motor_protection_supervisor_tb;
	import prot_pkg::*;
	typedef struct {logic ot; logic uv; drive_t exp;} row_t;
	logic i_clk, i_rst, cs, hall, osc, gnd, ot, uv, flip, brk, dir, brq;
	bridge_t o_bridge;
	drive_t o_drive_state;
	logic o_standby_state;
	int err_total, tests_run, n;
	// fault flag rows: temperature outranks supply lockout, which outranks normal drive
	row_t rows[5] = '{'{1'b0, 1'b0, DRV_NORMAL}, '{1'b1, 1'b0, DRV_ALL_OFF},
		'{1'b1, 1'b1, DRV_ALL_OFF}, '{1'b0, 1'b1, DRV_SHORT_BRAKE}, '{1'b0, 1'b0, DRV_NORMAL}};

	host_model host (.i_clk(i_clk), .i_rst(i_rst), .i_flip(flip), .i_brake(brk),
		.o_direction(dir), .o_brake_request(brq));
	motor_protection_supervisor dut (.i_clk(i_clk), .i_rst(i_rst), .i_current_sense_over(cs),
		.i_hall_pulse(hall), .i_lock_timer_cap_input(osc), .i_lock_timer_grounded(gnd),
		.i_over_temp(ot), .i_undervoltage(uv), .i_direction(dir), .i_brake_request(brq),
		.o_bridge(o_bridge), .o_drive_state(o_drive_state), .o_standby_state(o_standby_state));

	// 10 mhz clock
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// wait k edges, then step past them so outputs have settled
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask

	// compare state and standby; gate pattern only where the state fixes it
	task automatic chk(input drive_t e, input logic sb);
		logic bad;
		bad = (o_drive_state !== e) || (o_standby_state !== sb);
		case (e)
			DRV_FREE_RUN: bad = bad || ({o_bridge.high_on, o_bridge.low_on} !== 6'h08);
			DRV_ALL_OFF: bad = bad || ({o_bridge.high_on, o_bridge.low_on} !== 6'h00);
			DRV_SHORT_BRAKE: bad = bad || ({o_bridge.high_on, o_bridge.low_on} !== 6'h07);
			DRV_PWM_HOLD: bad = bad || (o_bridge.pwm_en !== 1'b0);
			default: bad = bad || (o_bridge.pwm_en !== 1'b1);
		endcase
		tests_run++;
		if (bad) begin
			err_total++;
			$display("[ERR] %0t want %0d got %0d standby %b", $time, e, o_drive_state,
				o_standby_state);
		end
	endtask

	// oscillator periods, two cycles per level so the synchroniser sees every edge
	task automatic osc_run(input int k);
		repeat (k) begin
			@(posedge i_clk);
			osc <= 1'b1;
			repeat (2) @(posedge i_clk);
			osc <= 1'b0;
			@(posedge i_clk);
		end
		cyc(4);
	endtask

	task automatic hall_pulse();
		@(posedge i_clk);
		hall <= 1'b1;
		repeat (3) @(posedge i_clk);
		hall <= 1'b0;
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		{i_rst, cs, hall, osc, gnd, ot, uv, flip, brk} = 9'h100;
		err_total = 0;
		tests_run = 0;
		begin : scenarios
		cyc(11);
		chk(DRV_SHORT_BRAKE, 1'b0);
		@(posedge i_clk);
		i_rst <= 1'b0;
		$display("test reset done");
		foreach (rows[i]) begin
			@(posedge i_clk);
			ot <= rows[i].ot;
			uv <= rows[i].uv;
			cyc(6);
			chk(rows[i].exp, 1'b0);
		end
		$display("test fault flags done");
		// a second trip inside the hold must not stretch it
		@(posedge i_clk);
		cs <= 1'b1;
		cyc(5);
		chk(DRV_PWM_HOLD, 1'b0);
		@(posedge i_clk);
		cs <= 1'b0;
		cyc(100);
		@(posedge i_clk);
		cs <= 1'b1;
		cyc(3);
		@(posedge i_clk);
		cs <= 1'b0;
		cyc(1);
		n = 0;
		while (o_drive_state !== DRV_NORMAL && n < 400) begin
			cyc(1);
			n++;
		end
		tests_run++;
		if (112 + n < OC_OFF_CYC || 112 + n > OC_OFF_CYC + 8) begin
			err_total++;
			$display("[ERR] %0t hold ended after %0d cycles", $time, 112 + n);
		end
		// a hold that never ends leaves nothing sane to test afterwards
		if (n >= 400) begin
			disable scenarios;
		end
		$display("test overcurrent done");
		osc_run(250);
		chk(DRV_NORMAL, 1'b0);
		osc_run(8);
		chk(DRV_FREE_RUN, 1'b0);
		osc_run(200);
		hall_pulse();
		osc_run(200);
		chk(DRV_FREE_RUN, 1'b0);
		osc_run(60);
		chk(DRV_FREE_RUN, 1'b1);
		@(posedge i_clk);
		flip <= 1'b1;
		@(posedge i_clk);
		flip <= 1'b0;
		cyc(6);
		chk(DRV_NORMAL, 1'b0);
		$display("test stall done");
		// overtemperature on top of free-run, then brake releases the stall
		osc_run(260);
		chk(DRV_FREE_RUN, 1'b0);
		@(posedge i_clk);
		ot <= 1'b1;
		cyc(6);
		chk(DRV_ALL_OFF, 1'b0);
		@(posedge i_clk);
		ot <= 1'b0;
		cyc(6);
		chk(DRV_FREE_RUN, 1'b0);
		@(posedge i_clk);
		brk <= 1'b1;
		cyc(6);
		chk(DRV_NORMAL, 1'b0);
		// brake held: no stall however long the rotor stands
		osc_run(300);
		chk(DRV_NORMAL, 1'b0);
		@(posedge i_clk);
		brk <= 1'b0;
		$display("test brake and precedence done");
		@(posedge i_clk);
		gnd <= 1'b1;
		osc_run(600);
		chk(DRV_NORMAL, 1'b0);
		$display("test grounded timer done");
		// mid-run reset: safe brake until the synchronisers refill, then normal
		@(posedge i_clk);
		i_rst <= 1'b1;
		cyc(3);
		chk(DRV_SHORT_BRAKE, 1'b0);
		@(posedge i_clk);
		i_rst <= 1'b0;
		cyc(2);
		chk(DRV_SHORT_BRAKE, 1'b0);
		cyc(1);
		chk(DRV_NORMAL, 1'b0);
		$display("test mid-run reset done");
		end
		final_report();
	end
endmodule // motor_protection_supervisor_tb

// *** prot_pkg.sv ***
// package: constants and carrier types for the motor protection supervisor
package prot_pkg;

	// lock-detection interval in oscillator periods
	localparam int unsigned LOCK_PERIODS = 256;
	localparam int unsigned LOCK_CNT_W = 9;
	localparam logic [LOCK_CNT_W-1:0] LOCK_TERM = 9'h100;
	localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_RST = 9'h000;

	// overcurrent pwm blanking time in ns, and derived cycle count at 10 mhz
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned OC_OFF_NS = 40000;
	localparam int unsigned OC_OFF_CYC = (OC_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OC_CNT_W = 9;
	localparam logic [OC_CNT_W-1:0] OC_LOAD = OC_CNT_W'(OC_OFF_CYC);
	localparam logic [OC_CNT_W-1:0] OC_CNT_RST = 9'h000;

	// bridge drive state as seen by the gate driver
	typedef enum logic [2:0] {
		DRV_NORMAL = 3'h0,
		DRV_PWM_HOLD = 3'h1,
		DRV_FREE_RUN = 3'h2,
		DRV_SHORT_BRAKE = 3'h3,
		DRV_ALL_OFF = 3'h4
	} drive_t;

	// stall supervisor states, gray along run -> free-run -> standby
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_FREE = 2'h1,
		ST_STANDBY = 2'h3
	} stall_t;

	// gate-level outputs, one bit per phase
	typedef struct packed {
		logic [2:0] high_on;
		logic [2:0] low_on;
		logic pwm_en;
	} bridge_t;

	localparam bridge_t BRIDGE_RST = '{high_on: 3'h0, low_on: 3'h7, pwm_en: 1'b0};

endpackage

// *** sync2.sv ***
// sync2: per-bit two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// asynchronous input and synchronised output
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// first stage is read only by the second
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					meta_ff[g] <= 1'b0;
					q_ff[g] <= 1'b0;
				end else begin
					meta_ff[g] <= i_d[g];
					q_ff[g] <= meta_ff[g];
				end
			end
		end
	endgenerate

	assign o_q = q_ff;
endmodule // sync2
